/* rtl/psrs_pkg.sv */
package psrs_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NPORTS = 13;
  localparam int PW = 4;
  localparam int AW = 8;
  localparam int DW = 8;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [AW-1:0] ADDR_PSR_BASE = 8'h01;
  localparam logic [AW-1:0] ADDR_CHIP_CFG = 8'h0E;
  localparam logic [AW-1:0] ADDR_GLOBAL_SEC = 8'h1D;
  localparam logic [AW-1:0] ADDR_SEC_CFG_BASE = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PSR_DIS = 0;
  localparam int PSR_LNKDIS = 1;
  localparam int PSR_PARTITION_RESET_CTL = 2;
  localparam int PSR_SQ = 3;
  localparam int PSR_PARTST = 4;
  localparam int PSR_LINKOK = 5;
  localparam int SCFG_MODE = 0;
  localparam int SCFG_SRC_CHK = 1;
  localparam int SCFG_DST_CHK = 2;
  localparam int SCFG_LEARN = 3;
  localparam int GSEC_LEARN = 0;
  localparam int GSEC_SRC_MISS = 1;
  localparam int CFG_SEC_EN = 0;

  // ****************************************************************
  // Reset values and random source
  // ****************************************************************
  localparam logic [DW-1:0] REG_ZERO = 8'h00;
  localparam int LFSR_W = 15;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h7FFF;
  localparam int LFSR_TAP_A = 14;
  localparam int LFSR_TAP_B = 13;

  // ****************************************************************
  // Packet phase
  // ****************************************************************
  typedef enum logic [1:0] {
    PSRS_IDLE = 2'b00,
    PSRS_HEAD = 2'b01,
    PSRS_DATA = 2'b10
  } psrs_phase_t;
endpackage

/* rtl/psrs_port_sel.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// One output lane: real or random data choice
// ****************************************************************
module psrs_port_sel
  import psrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pkt_active,
  input wire logic data_start,
  input wire logic mode,
  input wire logic src_chk,
  input wire logic dst_chk,
  input wire logic sa_match,
  input wire logic da_match,
  input wire logic blocked,
  input wire logic rx_bit,
  input wire logic rnd_bit,
  output logic tx_en,
  output logic tx_bit
);
  logic choose_random;
  logic use_random;
  logic random_now;

  // Disabled security or passing checks repeat real data
  assign choose_random = mode
    & ((src_chk & ~sa_match) | (dst_chk & ~da_match));
  assign random_now = data_start ? choose_random : use_random;

  // Choice frozen at data field start, kept to packet end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      use_random <= 1'b0;
    end else if (!pkt_active) begin
      use_random <= 1'b0;
    end else if (data_start) begin
      use_random <= choose_random;
    end
  end

  // Header passes unchanged; data field may be replaced
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_en <= 1'b0;
      tx_bit <= 1'b0;
    end else begin
      tx_en <= pkt_active & ~blocked;
      if (pkt_active && !blocked) begin
        tx_bit <= random_now ? rnd_bit : rx_bit;
      end else begin
        tx_bit <= 1'b0;
      end
    end
  end
endmodule // psrs_port_sel
`default_nettype wire

/* rtl/psrs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module psrs_top
  import psrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // Power-up configuration pins
  input wire logic powerup_config_load,
  input wire logic strap_security,
  input wire logic strap_learn,
  // Packet from the repeater core
  input wire logic pkt_active,
  input wire logic data_start,
  input wire logic rx_bit,
  input wire logic [PW-1:0] rx_port,
  input wire logic sa_match,
  input wire logic da_match,
  // Port status from partition and link logic
  input wire logic [NPORTS-1:0] partitioned,
  input wire logic [NPORTS-1:0] link_ok,
  // Port controls
  output logic [NPORTS-1:0] port_disable,
  output logic [NPORTS-1:0] link_check_disable,
  output logic [NPORTS-1:0] partition_reset_ctl,
  output logic [NPORTS-1:0] reduced_squelch,
  output logic [NPORTS-1:0] port_learn_enable,
  // Transmit lanes and source mismatch flag
  output logic [NPORTS-1:0] tx_en,
  output logic [NPORTS-1:0] tx_bit,
  output logic cascade_en,
  output logic cascade_bit,
  output logic source_mismatch_flag
);
  // ****************************************************************
  // State
  // ****************************************************************
  logic [NPORTS-1:0] port_security_mode;
  logic [NPORTS-1:0] source_addr_check_en;
  logic [NPORTS-1:0] dest_addr_check_en;
  logic global_security_enable;
  logic global_learn_enable;
  logic load_s1, load_s2, load_s3;
  logic sec_s1, sec_s2;
  logic lrn_s1, lrn_s2;
  logic load_rise;
  logic [LFSR_W-1:0] lfsr;
  logic [NPORTS-1:0] src_onehot;
  logic src_disabled;
  logic src_mode, src_check;
  psrs_phase_t phase;
  logic [DW-1:0] next_rdata;

  // ****************************************************************
  // Power-up load synchronisers
  // ****************************************************************

  // Pins are asynchronous; edge detect only behind stage two
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      load_s1 <= 1'b0;
      load_s2 <= 1'b0;
      load_s3 <= 1'b0;
      sec_s1 <= 1'b0;
      sec_s2 <= 1'b0;
      lrn_s1 <= 1'b0;
      lrn_s2 <= 1'b0;
    end else begin
      load_s1 <= powerup_config_load;
      load_s2 <= load_s1;
      load_s3 <= load_s2;
      sec_s1 <= strap_security;
      sec_s2 <= sec_s1;
      lrn_s1 <= strap_learn;
      lrn_s2 <= lrn_s1;
    end
  end

  assign load_rise = load_s2 & ~load_s3;

  // ****************************************************************
  // Global enables
  // ****************************************************************

  // Load strobe beats a same-cycle register write
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      global_security_enable <= 1'b0;
    end else if (load_rise) begin
      global_security_enable <= sec_s2;
    end else if (reg_wr && reg_addr == ADDR_CHIP_CFG) begin
      global_security_enable <= reg_wdata[CFG_SEC_EN];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      global_learn_enable <= 1'b0;
    end else if (load_rise) begin
      global_learn_enable <= lrn_s2;
    end else if (reg_wr && reg_addr == ADDR_GLOBAL_SEC) begin
      global_learn_enable <= reg_wdata[GSEC_LEARN];
    end
  end

  // ****************************************************************
  // Port status registers
  // ****************************************************************

  // Disable and link check are separate bits with separate outputs
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      port_disable <= '0;
      link_check_disable <= '0;
      reduced_squelch <= '0;
    end else begin
      for (int i = 0; i < NPORTS; i++) begin
        if (reg_wr && reg_addr == AW'(ADDR_PSR_BASE + i)) begin
          port_disable[i] <= reg_wdata[PSR_DIS];
          link_check_disable[i] <= reg_wdata[PSR_LNKDIS];
          reduced_squelch[i] <= reg_wdata[PSR_SQ];
        end
      end
    end
  end

  // Write-one pulse; partition logic resets and reconnects on it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      partition_reset_ctl <= '0;
    end else begin
      for (int i = 0; i < NPORTS; i++) begin
        partition_reset_ctl[i] <= reg_wr && reg_addr == AW'(ADDR_PSR_BASE + i)
                                  && reg_wdata[PSR_PARTITION_RESET_CTL];
      end
    end
  end

  // ****************************************************************
  // Port security configuration registers
  // ****************************************************************

  // Global enables hold bits set: the set wins over a clearing write
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      port_security_mode <= '0;
      source_addr_check_en <= '0;
      dest_addr_check_en <= '0;
      port_learn_enable <= '0;
    end else begin
      for (int i = 0; i < NPORTS; i++) begin
        if (global_security_enable) begin
          port_security_mode[i] <= 1'b1;
          source_addr_check_en[i] <= 1'b1;
          dest_addr_check_en[i] <= 1'b1;
        end else if (reg_wr && reg_addr == AW'(ADDR_SEC_CFG_BASE + i)) begin
          port_security_mode[i] <= reg_wdata[SCFG_MODE];
          source_addr_check_en[i] <= reg_wdata[SCFG_SRC_CHK];
          dest_addr_check_en[i] <= reg_wdata[SCFG_DST_CHK];
        end
        if (global_security_enable || global_learn_enable) begin
          port_learn_enable[i] <= 1'b1;
        end else if (reg_wr && reg_addr == AW'(ADDR_SEC_CFG_BASE + i)) begin
          port_learn_enable[i] <= reg_wdata[SCFG_LEARN];
        end
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Unmapped and reserved bits read as zero
  always_comb begin
    next_rdata = REG_ZERO;
    if (reg_addr == ADDR_CHIP_CFG) begin
      next_rdata[CFG_SEC_EN] = global_security_enable;
    end
    if (reg_addr == ADDR_GLOBAL_SEC) begin
      next_rdata[GSEC_LEARN] = global_learn_enable;
      next_rdata[GSEC_SRC_MISS] = source_mismatch_flag;
    end
    for (int i = 0; i < NPORTS; i++) begin
      if (reg_addr == AW'(ADDR_PSR_BASE + i)) begin
        next_rdata[PSR_DIS] = port_disable[i];
        next_rdata[PSR_LNKDIS] = link_check_disable[i];
        next_rdata[PSR_SQ] = reduced_squelch[i];
        next_rdata[PSR_PARTST] = partitioned[i];
        next_rdata[PSR_LINKOK] = link_ok[i];
      end
      if (reg_addr == AW'(ADDR_SEC_CFG_BASE + i)) begin
        next_rdata[SCFG_MODE] = port_security_mode[i];
        next_rdata[SCFG_SRC_CHK] = source_addr_check_en[i];
        next_rdata[SCFG_DST_CHK] = dest_addr_check_en[i];
        next_rdata[SCFG_LEARN] = port_learn_enable[i];
      end
    end
  end

  // Data only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= REG_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= REG_ZERO;
    end
  end

  // ****************************************************************
  // Pseudo-random source
  // ****************************************************************

  // Free running so random fields differ packet to packet
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= {lfsr[LFSR_W-2:0], lfsr[LFSR_TAP_A] ^ lfsr[LFSR_TAP_B]};
    end
  end

  // ****************************************************************
  // Packet phase and source mismatch flag
  // ****************************************************************

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase <= PSRS_IDLE;
    end else begin
      unique case (phase)
        PSRS_IDLE: begin
          if (pkt_active) begin
            phase <= data_start ? PSRS_DATA : PSRS_HEAD;
          end
        end
        PSRS_HEAD: begin
          if (!pkt_active) begin
            phase <= PSRS_IDLE;
          end else if (data_start) begin
            phase <= PSRS_DATA;
          end
        end
        PSRS_DATA: begin
          if (!pkt_active) begin
            phase <= PSRS_IDLE;
          end
        end
        default: phase <= PSRS_IDLE;
      endcase
    end
  end

  // Updated once per accepted packet, as the data field opens
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      source_mismatch_flag <= 1'b0;
    end else if (pkt_active && data_start && phase != PSRS_DATA && !src_disabled) begin
      source_mismatch_flag <= ~sa_match;
    end
  end

  // ****************************************************************
  // Source port lookup
  // ****************************************************************

  // A disabled source is not repeated anywhere
  always_comb begin
    src_onehot = '0;
    for (int i = 0; i < NPORTS; i++) begin
      src_onehot[i] = (rx_port == PW'(i));
    end
  end

  assign src_disabled = |(src_onehot & port_disable);
  assign src_mode = |(src_onehot & port_security_mode);
  assign src_check = |(src_onehot & source_addr_check_en);

  // ****************************************************************
  // Output lanes
  // ****************************************************************

  // Own settings decide own ports; peers decide theirs
  for (genvar g = 0; g < NPORTS; g++) begin : g_lane
    psrs_port_sel u_sel (
      .mclk(mclk),
      .rstn(rstn),
      .pkt_active(pkt_active),
      .data_start(data_start),
      .mode(port_security_mode[g]),
      .src_chk(source_addr_check_en[g]),
      .dst_chk(dest_addr_check_en[g]),
      .sa_match(sa_match),
      .da_match(da_match),
      .blocked(port_disable[g] | src_disabled | src_onehot[g]),
      .rx_bit(rx_bit),
      .rnd_bit(lfsr[0]),
      .tx_en(tx_en[g]),
      .tx_bit(tx_bit[g])
    );
  end

  // Bus ignores destination: peers check it themselves
  psrs_port_sel u_cascade (
    .mclk(mclk),
    .rstn(rstn),
    .pkt_active(pkt_active),
    .data_start(data_start),
    .mode(src_mode),
    .src_chk(src_check),
    .dst_chk(1'b0),
    .sa_match(sa_match),
    .da_match(da_match),
    .blocked(src_disabled),
    .rx_bit(rx_bit),
    .rnd_bit(lfsr[0]),
    .tx_en(cascade_en),
    .tx_bit(cascade_bit)
  );
endmodule // psrs_top
`default_nettype wire

/* tb/psrs_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module psrs_top_asserts
  import psrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic pkt_active,
  input wire logic data_start,
  input wire logic rx_bit,
  input wire logic [PW-1:0] rx_port,
  input wire logic sa_match,
  input wire logic [NPORTS-1:0] port_disable,
  input wire logic [NPORTS-1:0] partition_reset_ctl,
  input wire logic [NPORTS-1:0] port_learn_enable,
  input wire logic [NPORTS-1:0] tx_en,
  input wire logic [NPORTS-1:0] tx_bit,
  input wire logic cascade_en,
  input wire logic cascade_bit,
  input wire logic source_mismatch_flag
);
  logic in_data;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Data field reached; header checks stop there
  always_ff @(posedge mclk) begin
    if (!rstn || !pkt_active) begin
      in_data <= 1'h0;
    end else if (data_start) begin
      in_data <= 1'h1;
    end
  end
  // ****
  // Checks
  // ****
  idle_lanes_a: assert property (
    !$past(pkt_active) |-> tx_en == '0 && !cascade_en) else $error("lane busy when idle");
  lane_enable_a: assert property (
    $past(pkt_active) && $past(port_disable) == '0
    |-> cascade_en && tx_en == ~(13'h0001 << $past(rx_port))) else $error("wrong lanes on");
  header_real_a: assert property (
    $past(pkt_active && !data_start && !in_data) && cascade_en |-> cascade_bit == $past(rx_bit)
    && (tx_bit & tx_en) == ({NPORTS{$past(rx_bit)}} & tx_en)) else $error("header changed");
  blocked_bit_a: assert property (
    (tx_bit & ~tx_en) == '0) else $error("bit on blocked lane");
  flag_source_a: assert property (
    !$stable(source_mismatch_flag) |-> $past(data_start)
    && source_mismatch_flag == !$past(sa_match)) else $error("flag wrong");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("read data without read");
  partition_reset_ctl_pulse_a: assert property (
    partition_reset_ctl != '0 |-> $past(reg_wr) && $past(reg_wdata[2])
    && $past(reg_addr) inside {[8'h01:8'h0D]}) else $error("stray partition reset");
  disable_write_a: assert property (
    $changed(port_disable) |-> $past(reg_wr)
    && $past(reg_addr) inside {[8'h01:8'h0D]}) else $error("disable moved alone");
  learn_hold_a: assert property (
    ($past(port_learn_enable) & ~port_learn_enable) != '0 |-> $past(reg_wr)
    && $past(reg_addr) inside {[8'h20:8'h2C]}) else $error("learn bit dropped");
endmodule // psrs_top_asserts
bind psrs_top psrs_top_asserts u_chk (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .pkt_active, .data_start, .rx_bit, .rx_port, .sa_match,
  .port_disable, .partition_reset_ctl, .port_learn_enable, .tx_en, .tx_bit,
  .cascade_en, .cascade_bit, .source_mismatch_flag);
`default_nettype wire

/* tb/psrs_cascade_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module psrs_cascade_peer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cascade_en,
  input wire logic cascade_bit,
  output logic [31:0] frame,
  output logic [7:0] frame_len
);
  logic was_en;
  // Takes the bus packet whole; shifts it into frame and counts frame_len
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      frame <= 32'h0;
      frame_len <= 8'h00;
      was_en <= 1'h0;
    end else begin
      was_en <= cascade_en;
      if (cascade_en) begin
        frame <= {frame[30:0], cascade_bit};
        frame_len <= was_en ? frame_len + 8'h01 : 8'h01;
      end
    end
  end
endmodule // psrs_cascade_peer
`default_nettype wire

/* tb/psrs_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module psrs_top_bench
  import psrs_pkg::*;
;
  localparam logic [23:0] PAT = 24'hC3A55A;
  logic mclk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic powerup_config_load = 1'h0, strap_security = 1'h0, strap_learn = 1'h0;
  logic pkt_active = 1'h0, data_start = 1'h0, rx_bit = 1'h0, sa_match = 1'h0, da_match = 1'h0;
  logic [PW-1:0] rx_port = '0;
  logic [NPORTS-1:0] partitioned = 13'h0002, link_ok = 13'h1FFF;
  logic [DW-1:0] reg_rdata;
  logic [NPORTS-1:0] port_disable, link_check_disable, partition_reset_ctl, reduced_squelch;
  logic [NPORTS-1:0] port_learn_enable, tx_en, tx_bit, en_mid;
  logic cascade_en, cascade_bit, source_mismatch_flag, cen_mid;
  logic [31:0] frame;
  logic [7:0] frame_len;
  logic [23:0] txw;
  int err_count = 0, check_count = 0;
  psrs_top DUT (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .powerup_config_load, .strap_security, .strap_learn, .pkt_active, .data_start, .rx_bit,
    .rx_port, .sa_match, .da_match, .partitioned, .link_ok, .port_disable,
    .link_check_disable, .partition_reset_ctl, .reduced_squelch, .port_learn_enable,
    .tx_en, .tx_bit, .cascade_en, .cascade_bit, .source_mismatch_flag);
  psrs_cascade_peer u_peer (.mclk, .rstn, .cascade_en, .cascade_bit, .frame, .frame_len);
  // 20 MHz
  always #25 mclk = ~mclk;
  // ****
  // Shared tasks
  // ****
  task automatic fail(input string msg);
    err_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("byte %h want %h", got, exp));
  endtask
  task automatic chk13(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("ports %h want %h", got, exp));
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) fail($sformatf("bit %b want %b", got, exp));
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rstn <= 1'h0;
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    @(negedge mclk);
  endtask
  // Ends on a falling edge so outputs can be looked at right away
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    chk8(reg_rdata, exp);
  endtask
  // 8 header bits then 16 data bits from rx_port; matches flip after data start
  task automatic send(input logic s, input logic d);
    for (int k = 0; k < 25; k++) begin
      @(posedge mclk);
      pkt_active <= (k < 24);
      rx_bit <= (k < 24) ? PAT[23-k] : 1'h0;
      data_start <= (k == 8);
      sa_match <= (k == 8) ? s : ~s;
      da_match <= (k == 8) ? d : ~d;
      @(negedge mclk);
      if (k > 0) txw[24-k] = tx_bit[1];
      if (k == 12) en_mid = tx_en;
      if (k == 12) cen_mid = cascade_en;
    end
    @(negedge mclk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    chk13(port_learn_enable, 13'h0000);
    rd(ADDR_PSR_BASE, 8'h20);
    rd(ADDR_SEC_CFG_BASE, 8'h00);
    rd(ADDR_GLOBAL_SEC, 8'h00);
    rd(ADDR_CHIP_CFG, 8'h00);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
  endtask
  task automatic t_psr();
    wr(ADDR_PSR_BASE + 8'h01, 8'h0B);
    chk13(port_disable, 13'h0002);
    chk13(link_check_disable, 13'h0002);
    chk13(reduced_squelch, 13'h0002);
    rd(ADDR_PSR_BASE + 8'h01, 8'h3B);
    wr(ADDR_PSR_BASE + 8'h01, 8'h04);
    chk13(partition_reset_ctl, 13'h0002);
    chk13(port_disable, 13'h0000);
    @(negedge mclk);
    chk13(partition_reset_ctl, 13'h0000);
    rd(ADDR_PSR_BASE + 8'h01, 8'h30);
  endtask
  // Every mode, check and match combination; ports 0 and 1 set alike
  task automatic t_table();
    logic [4:0] c;
    logic pr, cr;
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      wr(ADDR_SEC_CFG_BASE, {5'h00, c[2], c[3], c[4]});
      wr(ADDR_SEC_CFG_BASE + 8'h01, {5'h00, c[2], c[3], c[4]});
      pr = c[4] & ((c[3] & ~c[1]) | (c[2] & ~c[0]));
      cr = c[4] & c[3] & ~c[1];
      send(c[1], c[0]);
      chk8(txw[23:16], PAT[23:16]);
      chk1(txw[15:0] !== PAT[15:0], pr);
      chk1(frame[15:0] !== PAT[15:0], cr);
      chk8(frame_len, 8'h18);
      chk1(source_mismatch_flag, ~c[1]);
    end
    wr(ADDR_SEC_CFG_BASE, 8'h00);
    wr(ADDR_SEC_CFG_BASE + 8'h01, 8'h00);
  endtask
  task automatic t_block();
    wr(ADDR_PSR_BASE + 8'h03, 8'h01);
    wr(ADDR_PSR_BASE + 8'h04, 8'h02);
    send(1'h1, 1'h1);
    chk13(en_mid, 13'h1FF6);
    chk1(cen_mid, 1'h1);
    wr(ADDR_PSR_BASE, 8'h01);
    send(1'h0, 1'h1);
    chk13(en_mid, 13'h0000);
    chk1(cen_mid, 1'h0);
    chk1(source_mismatch_flag, 1'h0);
    // Another source: only the disabled ports 0 and 3 and the source itself stay quiet
    @(posedge mclk);
    rx_port <= 4'h2;
    send(1'h0, 1'h1);
    chk13(en_mid, 13'h1FF2);
    chk1(cen_mid, 1'h1);
    chk1(source_mismatch_flag, 1'h1);
    @(posedge mclk);
    rx_port <= 4'h0;
    for (int p = 0; p < 5; p++) wr(ADDR_PSR_BASE + 8'(p), 8'h00);
  endtask
  task automatic t_learn();
    wr(ADDR_GLOBAL_SEC, 8'h01);
    @(negedge mclk);
    chk13(port_learn_enable, 13'h1FFF);
    wr(ADDR_SEC_CFG_BASE + 8'h05, 8'h00);
    rd(ADDR_SEC_CFG_BASE + 8'h05, 8'h08);
    rd(ADDR_GLOBAL_SEC, 8'h03);
  endtask
  task automatic t_secure();
    wr(ADDR_CHIP_CFG, 8'h01);
    wr(ADDR_SEC_CFG_BASE + 8'h05, 8'h00);
    rd(ADDR_SEC_CFG_BASE + 8'h05, 8'h0F);
    rd(ADDR_CHIP_CFG, 8'h01);
    send(1'h0, 1'h1);
    chk1(txw[15:0] !== PAT[15:0], 1'h1);
    wr(ADDR_CHIP_CFG, 8'h00);
    rd(ADDR_SEC_CFG_BASE + 8'h0C, 8'h0F);
  endtask
  // Pin held well past the synchroniser depth
  task automatic t_strap();
    do_reset();
    @(posedge mclk);
    strap_security <= 1'h1;
    strap_learn <= 1'h1;
    powerup_config_load <= 1'h1;
    repeat (4) @(posedge mclk);
    powerup_config_load <= 1'h0;
    repeat (4) @(posedge mclk);
    rd(ADDR_CHIP_CFG, 8'h01);
    rd(ADDR_GLOBAL_SEC, 8'h01);
    rd(ADDR_SEC_CFG_BASE + 8'h07, 8'h0F);
    // Once both enables drop, a port's bits are software's again
    wr(ADDR_CHIP_CFG, 8'h00);
    wr(ADDR_GLOBAL_SEC, 8'h00);
    wr(ADDR_SEC_CFG_BASE + 8'h07, 8'h00);
    rd(ADDR_SEC_CFG_BASE + 8'h07, 8'h00);
    chk13(port_learn_enable, 13'h1F7F);
  endtask
  initial begin
    do_reset();
    t_regs();
    t_psr();
    t_table();
    t_block();
    t_learn();
    t_secure();
    t_strap();
    summarize();
  end
  // About nine times the expected run
  initial begin
    #500000;
    fail("watchdog");
    summarize();
  end
endmodule // psrs_top_bench
`default_nettype wire
